// >>> src/tpw_pkg.sv
// constants for the timer waveform generator
package tpw_pkg;
  // register indices on the plain register port
  localparam logic [2:0] ADDR_CTRL_A   = 3'h0; // timer_control_a
  localparam logic [2:0] ADDR_CTRL_B   = 3'h1; // wave_mode_high_bit, tick sel
  localparam logic [2:0] ADDR_COUNT    = 3'h2; // counter_value
  localparam logic [2:0] ADDR_CMP_A    = 3'h3; // compare_a_value
  localparam logic [2:0] ADDR_CMP_B    = 3'h4; // compare_b_value
  localparam logic [2:0] ADDR_FLAGS    = 3'h5; // flags, write one to clear
  localparam logic [2:0] ADDR_PIN_DIR  = 3'h6; // pin direction bits

  // timer_control_a layout
  localparam int CTRL_A_MODE_A_HI = 7;
  localparam int CTRL_A_MODE_A_LO = 6;
  localparam int CTRL_A_MODE_B_HI = 5;
  localparam int CTRL_A_MODE_B_LO = 4;
  localparam int CTRL_A_WAVE_HI   = 1;
  localparam int CTRL_A_WAVE_LO   = 0;
  localparam logic [7:0] CTRL_A_WMASK = 8'hF3; // bits 3:2 read zero
  localparam logic [7:0] CTRL_A_RESET = 8'h00;

  // control b layout
  localparam int CTRL_B_WAVE_HI = 3;
  localparam int CTRL_B_CS_HI   = 2;
  localparam int CTRL_B_CS_LO   = 0;
  localparam logic [7:0] CTRL_B_WMASK = 8'h0F;

  // flag and pin direction bit positions
  localparam int FLAG_OVF   = 0;
  localparam int FLAG_CMP_A = 1;
  localparam int FLAG_CMP_B = 2;
  localparam int PIN_DIR_A  = 0;
  localparam int PIN_DIR_B  = 1;

  localparam logic [7:0] CNT_BOTTOM = 8'h00;
  localparam logic [7:0] CNT_MAX    = 8'hFF;

  // wave modes
  localparam logic [2:0] WM_NORMAL   = 3'h0;
  localparam logic [2:0] WM_PC_FF    = 3'h1;
  localparam logic [2:0] WM_CTC      = 3'h2;
  localparam logic [2:0] WM_FAST_FF  = 3'h3;
  localparam logic [2:0] WM_PC_CMP   = 3'h5;
  localparam logic [2:0] WM_FAST_CMP = 3'h7;

  // output modes
  localparam logic [1:0] OM_OFF    = 2'h0;
  localparam logic [1:0] OM_TOGGLE = 2'h1;
  localparam logic [1:0] OM_CLEAR  = 2'h2;
  localparam logic [1:0] OM_SET    = 2'h3;

  // prescale tick selections and divide factors
  localparam logic [2:0] CS_STOP = 3'h0;
  localparam logic [2:0] CS_DIV1 = 3'h1;
  localparam logic [2:0] CS_DIV8 = 3'h2;
  localparam logic [2:0] CS_D64  = 3'h3;
  localparam logic [2:0] CS_D256 = 3'h4;
  localparam logic [2:0] CS_D1K  = 3'h5;
  localparam int PRESCALE_W = 10;
endpackage

// >>> src/tpw_waveform_gen.sv
// timer8 waveform generator: counter, compare units, pwm outputs
//
// The address map and the strobed register port were left to the implementer.
`timescale 1ns/1ps
// ------------------------------------------------------------------
// ------------------------------------------------------------------
module tpw_waveform_gen (
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       reset_n,
  // register port
  input  wire logic [2:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // channel pins
  output logic            wave_out_a,
  output logic            wave_out_a_oe,
  output logic            wave_out_b,
  output logic            wave_out_b_oe,
  // flag levels for the interrupt logic outside
  output logic            overflow_flag,
  output logic            compare_a_flag,
  output logic            compare_b_flag
);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [7:0] ctrl_a_r;
  logic [7:0] ctrl_b_r;
  logic [7:0] count_r,   count_nxt;
  logic [7:0] cmp_a_buf_r, cmp_b_buf_r;
  logic [7:0] cmp_a_r,   cmp_b_r;
  logic [1:0] pin_dir_r;
  logic       ovf_r, cmpa_f_r, cmpb_f_r;
  logic       down_r,    down_nxt;
  logic       chan_a_r,  chan_a_nxt;
  logic       chan_b_r,  chan_b_nxt;
  logic [tpw_pkg::PRESCALE_W-1:0] presc_r;
  logic [7:0] rdata_r;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  wire [2:0] wave_mode_select = {ctrl_b_r[tpw_pkg::CTRL_B_WAVE_HI],
    ctrl_a_r[tpw_pkg::CTRL_A_WAVE_HI:tpw_pkg::CTRL_A_WAVE_LO]};
  wire       wave_mode_high_bit = ctrl_b_r[tpw_pkg::CTRL_B_WAVE_HI];
  wire [1:0] output_mode_a =
    ctrl_a_r[tpw_pkg::CTRL_A_MODE_A_HI:tpw_pkg::CTRL_A_MODE_A_LO];
  wire [1:0] output_mode_b =
    ctrl_a_r[tpw_pkg::CTRL_A_MODE_B_HI:tpw_pkg::CTRL_A_MODE_B_LO];
  wire [2:0] tick_sel =
    ctrl_b_r[tpw_pkg::CTRL_B_CS_HI:tpw_pkg::CTRL_B_CS_LO];

  // mode classes
  wire is_fast = (wave_mode_select == tpw_pkg::WM_FAST_FF) ||
                 (wave_mode_select == tpw_pkg::WM_FAST_CMP);
  wire is_pc   = (wave_mode_select == tpw_pkg::WM_PC_FF) ||
                 (wave_mode_select == tpw_pkg::WM_PC_CMP);
  wire is_ctc  = (wave_mode_select == tpw_pkg::WM_CTC);
  // reserved modes 4 and 6 fall through to the plain up-count
  wire is_pwm  = is_fast || is_pc;
  wire top_is_cmp = wave_mode_high_bit || is_ctc;

  // top source: 0xFF or channel a compare value
  wire [7:0] top_val = top_is_cmp ? cmp_a_r : tpw_pkg::CNT_MAX;
  wire at_top    = (count_r == top_val);
  wire at_bottom = (count_r == tpw_pkg::CNT_BOTTOM);
  wire at_max    = (count_r == tpw_pkg::CNT_MAX);

  // ----------------------------------------------------------------
  // prescaler tick, one clock wide
  // ----------------------------------------------------------------
  wire [tpw_pkg::PRESCALE_W-1:0] presc_inc =
    presc_r + {{(tpw_pkg::PRESCALE_W-1){1'b0}}, 1'b1};
  logic timer_tick;
  always_comb begin
    case (tick_sel)
      tpw_pkg::CS_DIV1: timer_tick = 1'b1;
      tpw_pkg::CS_DIV8: timer_tick = (presc_r[2:0] == 3'h7);
      tpw_pkg::CS_D64:  timer_tick = (presc_r[5:0] == 6'h3F);
      tpw_pkg::CS_D256: timer_tick = (presc_r[7:0] == 8'hFF);
      tpw_pkg::CS_D1K:  timer_tick = (presc_r == 10'h3FF);
      default:          timer_tick = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // compare events
  // ----------------------------------------------------------------
  wire match_a = timer_tick && (count_r == cmp_a_r);
  wire match_b = timer_tick && (count_r == cmp_b_r);
  // register write strobes
  wire wr_ctrl_a = reg_wr && (reg_addr == tpw_pkg::ADDR_CTRL_A);
  wire wr_ctrl_b = reg_wr && (reg_addr == tpw_pkg::ADDR_CTRL_B);
  wire wr_count  = reg_wr && (reg_addr == tpw_pkg::ADDR_COUNT);
  wire wr_cmp_a  = reg_wr && (reg_addr == tpw_pkg::ADDR_CMP_A);
  wire wr_cmp_b  = reg_wr && (reg_addr == tpw_pkg::ADDR_CMP_B);
  wire wr_flags  = reg_wr && (reg_addr == tpw_pkg::ADDR_FLAGS);
  wire wr_dir    = reg_wr && (reg_addr == tpw_pkg::ADDR_PIN_DIR);

  // compare update point: at top in pwm, always otherwise
  wire pc_reload   = is_pc && timer_tick && at_top;
  wire fast_reload = is_fast && timer_tick && at_top;
  wire cmp_reload  = !is_pwm || pc_reload || fast_reload;

  // ----------------------------------------------------------------
  // counter sequence
  // ----------------------------------------------------------------
  always_comb begin
    count_nxt = count_r;
    down_nxt  = down_r;
    if (timer_tick) begin
      if (is_pc) begin
        if (at_top) begin
          down_nxt  = 1'b1;
          count_nxt = count_r - 8'h01;
        end else if (at_bottom) begin
          down_nxt  = 1'b0;
          count_nxt = count_r + 8'h01;
        end else if (down_r) begin
          count_nxt = count_r - 8'h01;
        end else begin
          count_nxt = count_r + 8'h01;
        end
      end else if ((is_fast || is_ctc) && at_top) begin
        count_nxt = tpw_pkg::CNT_BOTTOM;
        down_nxt  = 1'b0;
      end else begin
        count_nxt = count_r + 8'h01;
        down_nxt  = 1'b0;
      end
    end
    if (wr_count) begin
      count_nxt = reg_wdata;
    end
  end

  // ----------------------------------------------------------------
  // flag events
  // ----------------------------------------------------------------
  wire ovf_ev = timer_tick && (is_pc ? at_bottom :
                is_fast ? at_top :
                at_max);
  // match a in ctc or mode 7 both clears counter and sets flag
  wire cmpa_ev = match_a;
  wire cmpb_ev = match_b;

  // ----------------------------------------------------------------
  // per channel waveform action, shared by both channels
  // ----------------------------------------------------------------
  function automatic logic chan_next(
    input logic       cur,
    input logic [1:0] om,
    input logic       match,
    input logic [7:0] cmp,
    input logic       may_toggle
  );
    logic nxt;
    logic cmp_top;
    nxt     = cur;
    cmp_top = (cmp == top_val);
    if (is_fast) begin
      if (om[1]) begin
        // top action always wins; a match on top itself is ignored
        if (timer_tick && at_top) begin
          nxt = !om[0];
        end else if (match) begin
          nxt = om[0];
        end
      end else if (om == tpw_pkg::OM_TOGGLE && may_toggle && match) begin
        nxt = !cur;
      end
    end else if (is_pc) begin
      if (om[1]) begin
        // compare at or above top holds the down-count level, so a
        // max compare stays steady instead of dipping for one tick
        if (timer_tick && at_top && cmp_top) begin
          nxt = !om[0];
        end else if (timer_tick && at_top && cmp == tpw_pkg::CNT_MAX) begin
          nxt = !om[0];
        end else if (timer_tick && at_bottom) begin
          // bottom: state implied by up match at next count
          nxt = (cmp == tpw_pkg::CNT_BOTTOM) ? om[0] : !om[0];
        end else if (match) begin
          nxt = down_r ? !om[0] : om[0];
        end
      end else if (om == tpw_pkg::OM_TOGGLE && may_toggle && match) begin
        nxt = !cur;
      end
    end else if (match) begin
      case (om)
        tpw_pkg::OM_TOGGLE: nxt = !cur;
        tpw_pkg::OM_CLEAR:  nxt = 1'b0;
        tpw_pkg::OM_SET:    nxt = 1'b1;
        default:            nxt = cur;
      endcase
    end
    return nxt;
  endfunction

  // always_comb, not assign: the function reads mode, count and tick
  // directly, and only a process wakes on those hidden reads
  always_comb begin
    chan_a_nxt = chan_next(chan_a_r, output_mode_a, match_a, cmp_a_r,
                           wave_mode_high_bit);
    chan_b_nxt = chan_next(chan_b_r, output_mode_b, match_b, cmp_b_r,
                           1'b0);
  end

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  logic [7:0] rd_mux;
  always_comb begin
    case (reg_addr)
      tpw_pkg::ADDR_CTRL_A:  rd_mux = ctrl_a_r;
      tpw_pkg::ADDR_CTRL_B:  rd_mux = ctrl_b_r;
      tpw_pkg::ADDR_COUNT:   rd_mux = count_r;
      tpw_pkg::ADDR_CMP_A:   rd_mux = cmp_a_buf_r;
      tpw_pkg::ADDR_CMP_B:   rd_mux = cmp_b_buf_r;
      tpw_pkg::ADDR_FLAGS:   rd_mux = {5'h00, cmpb_f_r, cmpa_f_r, ovf_r};
      tpw_pkg::ADDR_PIN_DIR: rd_mux = {6'h00, pin_dir_r};
      default:               rd_mux = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------
  // control and compare registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      ctrl_a_r    <= tpw_pkg::CTRL_A_RESET;
      ctrl_b_r    <= 8'h00;
      pin_dir_r   <= 2'h0;
      cmp_a_buf_r <= 8'h00;
      cmp_b_buf_r <= 8'h00;
      cmp_a_r     <= 8'h00;
      cmp_b_r     <= 8'h00;
      presc_r     <= '0;
    end else begin
      presc_r <= presc_inc;
      // reserved bits are masked so they always read back zero
      if (wr_ctrl_a) begin
        ctrl_a_r <= reg_wdata & tpw_pkg::CTRL_A_WMASK;
      end
      if (wr_ctrl_b) begin
        ctrl_b_r <= reg_wdata & tpw_pkg::CTRL_B_WMASK;
      end
      if (wr_dir) begin
        pin_dir_r <= reg_wdata[1:0];
      end
      // software always sees the buffer, not the live comparator
      if (wr_cmp_a) begin
        cmp_a_buf_r <= reg_wdata;
      end
      if (wr_cmp_b) begin
        cmp_b_buf_r <= reg_wdata;
      end
      // buffered copies move to the comparators at the update point
      if (cmp_reload) begin
        cmp_a_r <= wr_cmp_a ? reg_wdata : cmp_a_buf_r;
        cmp_b_r <= wr_cmp_b ? reg_wdata : cmp_b_buf_r;
      end
    end
  end

  // ----------------------------------------------------------------
  // counter, flags, channel state; set wins over clear
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      count_r  <= 8'h00;
      down_r   <= 1'b0;
      ovf_r    <= 1'b0;
      cmpa_f_r <= 1'b0;
      cmpb_f_r <= 1'b0;
      chan_a_r <= 1'b0;
      chan_b_r <= 1'b0;
      rdata_r  <= 8'h00;
    end else begin
      count_r  <= count_nxt;
      down_r   <= down_nxt;
      ovf_r    <= ovf_ev  || (ovf_r  &&
                  !(wr_flags && reg_wdata[tpw_pkg::FLAG_OVF]));
      cmpa_f_r <= cmpa_ev || (cmpa_f_r &&
                  !(wr_flags && reg_wdata[tpw_pkg::FLAG_CMP_A]));
      cmpb_f_r <= cmpb_ev || (cmpb_f_r &&
                  !(wr_flags && reg_wdata[tpw_pkg::FLAG_CMP_B]));
      chan_a_r <= chan_a_nxt;
      chan_b_r <= chan_b_nxt;
      rdata_r  <= reg_rd ? rd_mux : 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // pin drive: override only when mode nonzero and pin is output
  // ----------------------------------------------------------------
  logic out_a_r, oe_a_r, out_b_r, oe_b_r;
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      out_a_r <= 1'b0;
      oe_a_r  <= 1'b0;
      out_b_r <= 1'b0;
      oe_b_r  <= 1'b0;
    end else begin
      out_a_r <= chan_a_nxt;
      out_b_r <= chan_b_nxt;
      oe_a_r  <= pin_dir_r[tpw_pkg::PIN_DIR_A] &&
                 (output_mode_a != tpw_pkg::OM_OFF);
      oe_b_r  <= pin_dir_r[tpw_pkg::PIN_DIR_B] &&
                 (output_mode_b != tpw_pkg::OM_OFF);
    end
  end

  assign wave_out_a     = out_a_r;
  assign wave_out_a_oe  = oe_a_r;
  assign wave_out_b     = out_b_r;
  assign wave_out_b_oe  = oe_b_r;
  assign overflow_flag  = ovf_r;
  assign compare_a_flag = cmpa_f_r;
  assign compare_b_flag = cmpb_f_r;
  assign reg_rdata      = rdata_r;

endmodule // tpw_waveform_gen

// >>> verification/tpw_props.sv
// port-level assertions for the timer waveform generator
`timescale 1ns/1ps
module tpw_props (
  // clock and reset
  input wire logic       ref_clk,
  input wire logic       reset_n,
  // register port
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  // pins and flags
  input wire logic       wave_out_a,
  input wire logic       wave_out_a_oe,
  input wire logic       wave_out_b,
  input wire logic       wave_out_b_oe,
  input wire logic       overflow_flag,
  input wire logic       compare_a_flag,
  input wire logic       compare_b_flag
);
  // ----------------------------------------------------------------
  // shadow copies of the writable control state
  // ----------------------------------------------------------------
  logic [7:0] ctrl_a_r, ctrl_b_r, dir_r;
  wire        want_a = (ctrl_a_r[7:6] != 2'h0) && dir_r[0];
  wire        want_b = (ctrl_a_r[5:4] != 2'h0) && dir_r[1];
  wire        clr_wr = reg_wr && (reg_addr == tpw_pkg::ADDR_FLAGS);
  // shadow follows writes only, so it never copies the design's mistakes
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      ctrl_a_r <= 8'h00;
      ctrl_b_r <= 8'h00;
      dir_r    <= 8'h00;
    end else if (reg_wr) begin
      if (reg_addr == 3'h0) ctrl_a_r <= reg_wdata & 8'hF3;
      if (reg_addr == 3'h1) ctrl_b_r <= reg_wdata & 8'h0F;
      if (reg_addr == 3'h6) dir_r <= reg_wdata & 8'h03;
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  // three cycles with no tick: any tick already in flight has landed
  sequence s_stopped;
    (ctrl_b_r[2:0] == 3'h0) [*3];
  endsequence
  a_rdata_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not zero outside read answer");
  a_ctrl_a_back: assert property (
    reg_rd && reg_addr == 3'h0 |=> reg_rdata == $past(ctrl_a_r))
    else $error("control a readback wrong");
  a_unmapped_zero: assert property (reg_rd && reg_addr == 3'h7 |=>
    reg_rdata == 8'h00) else $error("unmapped read not zero");
  a_pin_a_gate: assert property ($stable(want_a) [*3] |->
    wave_out_a_oe == want_a) else $error("pin a enable wrong");
  a_pin_b_gate: assert property ($stable(want_b) [*3] |->
    wave_out_b_oe == want_b) else $error("pin b enable wrong");
  a_stop_no_ovf: assert property (s_stopped |->
    !$rose(overflow_flag) && !$rose(compare_a_flag))
    else $error("flag set with tick stopped");
  a_stop_wave_hold: assert property (s_stopped ##1 (ctrl_b_r[2:0] == 3'h0)
    |-> $stable(wave_out_b)) else $error("wave b moved without tick");
  a_flag_clear: assert property (s_stopped ##0 (clr_wr && reg_wdata[0] &&
    reg_wdata[2]) |=> !overflow_flag && !compare_b_flag)
    else $error("flag not cleared by write");
endmodule // tpw_props
bind tpw_waveform_gen tpw_props u_props (.ref_clk(ref_clk),
  .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .wave_out_a(wave_out_a), .wave_out_a_oe(wave_out_a_oe),
  .wave_out_b(wave_out_b), .wave_out_b_oe(wave_out_b_oe),
  .overflow_flag(overflow_flag), .compare_a_flag(compare_a_flag),
  .compare_b_flag(compare_b_flag));

// >>> verification/tb.sv
// self-checking bench for the timer waveform generator
`timescale 1ns/1ps
module tb;
  logic       ref_clk, reset_n, reg_wr, reg_rd;
  logic [2:0] reg_addr;
  logic [7:0] reg_wdata;
  wire  [7:0] reg_rdata;
  wire        wave_out_a, wave_out_a_oe, wave_out_b, wave_out_b_oe;
  wire        overflow_flag, compare_a_flag, compare_b_flag;
  int         fail_count, samples_checked, hi_a, hi_b, up_a, up_b;

  tpw_waveform_gen u_dut (.ref_clk(ref_clk), .reset_n(reset_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .wave_out_a(wave_out_a),
    .wave_out_a_oe(wave_out_a_oe), .wave_out_b(wave_out_b),
    .wave_out_b_oe(wave_out_b_oe), .overflow_flag(overflow_flag),
    .compare_a_flag(compare_a_flag), .compare_b_flag(compare_b_flag));

  // 100 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic chk(input string nm, input logic [15:0] exp, got);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %s expected %0h seen %0h", nm, exp, got);
    end
  endtask

  // ----------------------------------------------------------------
  // register port cycles
  // ----------------------------------------------------------------
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  // data stands only in the cycle after the strobe
  task automatic rd(input logic [2:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 chk("reg_rdata", {8'h00, exp}, {8'h00, reg_rdata});
  endtask

  // stop, load compares in normal mode so they take at once, then run /1
  task automatic setup(input logic [7:0] ca, cb, ma, mb, input int settle);
    wr(tpw_pkg::ADDR_CTRL_B, 8'h00);
    wr(tpw_pkg::ADDR_CTRL_A, 8'h00);
    wr(tpw_pkg::ADDR_COUNT, 8'h00);
    wr(tpw_pkg::ADDR_CMP_A, ca);
    wr(tpw_pkg::ADDR_CMP_B, cb);
    wr(tpw_pkg::ADDR_CTRL_A, ma);
    wr(tpw_pkg::ADDR_CTRL_B, mb);
    repeat (settle) @(posedge ref_clk);
    wr(tpw_pkg::ADDR_FLAGS, 8'h07);
  endtask

  // high cycles and rising edges over a whole number of periods
  task automatic sample(input int n);
    logic pa, pb;
    #1;
    hi_a = 0;
    hi_b = 0;
    up_a = 0;
    up_b = 0;
    pa = wave_out_a;
    pb = wave_out_b;
    repeat (n) begin
      @(posedge ref_clk);
      #1;
      hi_a += int'(wave_out_a);
      hi_b += int'(wave_out_b);
      up_a += int'(wave_out_a && !pa);
      up_b += int'(wave_out_b && !pb);
      pa = wave_out_a;
      pb = wave_out_b;
    end
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 3'h0;
    reg_wdata = 8'h00;
    reset_n = 1'b0;
    fail_count = 0;
    samples_checked = 0;
    repeat (4) @(posedge ref_clk);
    reset_n <= 1'b1;
    for (int i = 0; i < 8; i++) rd(3'(i), 8'h00);
    wr(3'h7, 8'hFF);
    rd(3'h7, 8'h00);
    wr(tpw_pkg::ADDR_CTRL_A, 8'hFF);
    rd(tpw_pkg::ADDR_CTRL_A, 8'hF3);
    // fast pwm, top 0xFF: a non-inverting, b inverting at 0x40
    wr(tpw_pkg::ADDR_PIN_DIR, 8'h03);
    setup(8'h40, 8'h40, 8'hB3, 8'h01, 600);
    sample(512);
    chk("hi_a", 16'd130, hi_a[15:0]);
    chk("hi_b", 16'd382, hi_b[15:0]);
    chk("up_a", 16'd2, up_a[15:0]);
    chk("ovf", 16'h1, {15'h0, overflow_flag});
    chk("oe_a", 16'h1, {15'h0, wave_out_a_oe});
    chk("oe_b", 16'h1, {15'h0, wave_out_b_oe});
    wr(tpw_pkg::ADDR_PIN_DIR, 8'h00);
    repeat (2) @(posedge ref_clk);
    #1 chk("oe_a", 16'h0, {15'h0, wave_out_a_oe});
    // extreme compares: zero is a spike, max a steady level
    setup(8'h00, 8'hFF, 8'hA3, 8'h01, 600);
    sample(512);
    chk("spike", 16'd2, hi_a[15:0]);
    chk("steady", 16'd512, hi_b[15:0]);
    // top from compare a: toggle at half clock, b toggle unavailable
    setup(8'h00, 8'h00, 8'h53, 8'h09, 40);
    sample(64);
    chk("up_a", 16'd32, up_a[15:0]);
    chk("up_b", 16'd0, up_b[15:0]);
    chk("cmp_a", 16'h1, {15'h0, compare_a_flag});
    setup(8'h05, 8'h02, 8'h23, 8'h09, 40);
    sample(60);
    chk("hi_b", 16'd30, hi_b[15:0]);
    chk("up_b", 16'd10, up_b[15:0]);
    chk("cmp_b", 16'h1, {15'h0, compare_b_flag});
    // clear on compare: a toggles, b set, no wrap through max
    setup(8'h03, 8'h01, 8'h72, 8'h01, 40);
    sample(64);
    chk("up_a", 16'd8, up_a[15:0]);
    chk("hi_a", 16'd32, hi_a[15:0]);
    chk("b_set", 16'h1, {15'h0, wave_out_b});
    chk("cmp_a", 16'h1, {15'h0, compare_a_flag});
    chk("ovf", 16'h0, {15'h0, overflow_flag});
    // phase correct, top 0xFF
    setup(8'h40, 8'h00, 8'hA1, 8'h01, 1100);
    sample(1020);
    chk("hi_a", 16'd256, hi_a[15:0]);
    chk("up_a", 16'd2, up_a[15:0]);
    chk("hi_b", 16'd0, hi_b[15:0]);
    chk("ovf", 16'h1, {15'h0, overflow_flag});
    // phase correct, max compare on b: steady high, no one-tick dip
    setup(8'h40, 8'hFF, 8'hA1, 8'h01, 600);
    sample(510);
    chk("pc_max", 16'd510, hi_b[15:0]);
    // phase correct, top from compare a
    setup(8'h0A, 8'h04, 8'h21, 8'h09, 200);
    sample(100);
    chk("hi_b", 16'd40, hi_b[15:0]);
    chk("up_b", 16'd5, up_b[15:0]);
    wr(tpw_pkg::ADDR_CTRL_B, 8'h00);
    repeat (4) @(posedge ref_clk);
    wr(tpw_pkg::ADDR_FLAGS, 8'h07);
    stop_test;
  end

  // run needs under 6300 cycles; cut a hang well after that
  initial begin
    repeat (30000) @(posedge ref_clk);
    fail_count++;
    $display("watchdog expired");
    stop_test;
  end
endmodule // tb
